// ===== shared/solfl_defs.svh
`ifndef SOLFL_DEFS_SVH
`define SOLFL_DEFS_SVH

`define SOLFL_FRAME_BITS     24
`define SOLFL_LOAD_COUNT     8
`define SOLFL_LED_COUNT      8
`define SOLFL_GROUP_COUNT    2
`define SOLFL_GROUP_SIZE     4
`define SOLFL_LOAD_MSB       23
`define SOLFL_LOAD_LSB       16
`define SOLFL_RED_BIT(i)     (2 * (i) + 1)
`define SOLFL_ORANGE_BIT(i)  (2 * (i))
`define SOLFL_SYS_PERIOD_NS  20
`define SOLFL_RETRY_TIME_NS  1200000
`define SOLFL_RETRY_CYCLES   (`SOLFL_RETRY_TIME_NS / `SOLFL_SYS_PERIOD_NS)
`define SOLFL_RETRY_W        17
`define SOLFL_FRAME_ZERO     24'h000000
`define SOLFL_BYTE_ZERO      8'h00
`define SOLFL_RETRY_ZERO     17'h00000
`define SOLFL_RETRY_ONE      17'h00001

`endif

// ===== shared/solfl_pkg.sv
`include "solfl_defs.svh"

package solfl_pkg;

  typedef logic [`SOLFL_FRAME_BITS-1:0] solfl_frame_t;
  typedef logic [`SOLFL_LOAD_COUNT-1:0] solfl_chan_t;
  typedef logic [`SOLFL_RETRY_W-1:0]    solfl_retry_t;

  typedef enum logic [0:0]
  {
    CH_RUN,
    CH_TRIP
  } solfl_chan_e;

endpackage : solfl_pkg

// ===== shared/solfl_link_if.sv
`timescale 1ns/1ps

interface solfl_link_if;
  import solfl_pkg::*;

  logic         spiMosi;
  logic         selectLatchN;
  logic         linkClear;
  solfl_frame_t shiftWord;
  logic         misoBit;

  modport link
  (
    input  spiMosi,
    input  selectLatchN,
    input  linkClear,
    output shiftWord,
    output misoBit
  );

  modport core
  (
    output spiMosi,
    output selectLatchN,
    output linkClear,
    input  shiftWord,
    input  misoBit
  );

endinterface : solfl_link_if

// ===== verilog/solfl_link_shift.sv
`timescale 1ns/1ps
`include "solfl_defs.svh"

module solfl_link_shift
  import solfl_pkg::*;
(
  input wire logic spiClk,
  solfl_link_if.link lnk
);

  solfl_frame_t shift_reg;
  solfl_frame_t shift_next;
  logic         shiftEnable;

  // Shifting only while selected, so stray clocks leave the word alone
  assign shiftEnable = ~lnk.selectLatchN;
  // MSB first: new bit enters at the bottom, oldest leaves the top
  assign shift_next  = shiftEnable
                     ? {shift_reg[`SOLFL_FRAME_BITS-2:0], lnk.spiMosi}
                     : shift_reg;

  // ***************************************************************
  // Link clock shift chain
  // ***************************************************************
  // The serial clock may stop for good between edges, so clear cannot
  // wait for it; the clear comes from a core flop and loads a constant.
  always_ff @(posedge spiClk or posedge lnk.linkClear)
  begin
    if (lnk.linkClear)
      shift_reg <= `SOLFL_FRAME_ZERO;
    else
      shift_reg <= shift_next;
  end

  assign lnk.shiftWord = shift_reg;
  // Daisy chain out: the bit that falls off the end of the chain
  assign lnk.misoBit   = shift_reg[`SOLFL_FRAME_BITS-1];

endmodule : solfl_link_shift

// ===== verilog/solfl_top.sv
`timescale 1ns/1ps
`include "solfl_defs.svh"

module solfl_top
  import solfl_pkg::*;
#(
  parameter int RETRY_CYCLES = `SOLFL_RETRY_CYCLES
)
(
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        spiClk,
  input  wire logic                        spiMosi,
  input  wire logic                        selectLatchN,
  output wire logic                        misoOut,
  output wire logic                        misoOeN,
  input  wire logic                        outputClear,
  input  wire logic [`SOLFL_LOAD_COUNT-1:0]  overCurrent,
  input  wire logic [`SOLFL_GROUP_COUNT-1:0] overTemp,
  output wire logic [`SOLFL_LOAD_COUNT-1:0]  loadSwitchOutputs,
  output wire logic [`SOLFL_LED_COUNT-1:0]   ledRed,
  output wire logic [`SOLFL_LED_COUNT-1:0]   ledOrange,
  output wire logic                        globalFaultN
);

  // ***************************************************************
  // Functions
  // ***************************************************************

  // Spreads one flag per driver onto the channels of that driver
  function automatic solfl_chan_t groupSpread
  (
    input logic [`SOLFL_GROUP_COUNT-1:0] perGroup
  );
    solfl_chan_t spread;
    spread = `SOLFL_BYTE_ZERO;
    for (int c = 0; c < `SOLFL_LOAD_COUNT; c++)
      spread[c] = perGroup[c / `SOLFL_GROUP_SIZE];
    return spread;
  endfunction : groupSpread

  // Picks the red or orange LED bits out of the interleaved LED field
  function automatic logic [`SOLFL_LED_COUNT-1:0] ledPick
  (
    input solfl_frame_t frame,
    input logic         pickRed
  );
    logic [`SOLFL_LED_COUNT-1:0] leds;
    leds = `SOLFL_BYTE_ZERO;
    for (int i = 0; i < `SOLFL_LED_COUNT; i++)
      leds[i] = pickRed ? frame[`SOLFL_RED_BIT(i)]
                        : frame[`SOLFL_ORANGE_BIT(i)];
    return leds;
  endfunction : ledPick

  // ***************************************************************
  // Declarations
  // ***************************************************************

  solfl_link_if lnk ();

  logic         clrMeta_reg;
  logic         clrSync_reg;
  logic         selMeta_reg;
  logic         selSync_reg;
  logic         selLast_reg;
  solfl_chan_t  ocMeta_reg;
  solfl_chan_t  ocSync_reg;
  logic [`SOLFL_GROUP_COUNT-1:0] otMeta_reg;
  logic [`SOLFL_GROUP_COUNT-1:0] otSync_reg;
  solfl_frame_t wordMeta_reg;
  solfl_frame_t wordSync_reg;

  logic         linkClear_reg;
  solfl_frame_t frame_reg;
  solfl_frame_t frame_next;
  solfl_chan_t  load_reg;
  solfl_chan_t  load_next;
  logic [`SOLFL_LED_COUNT-1:0] red_reg;
  logic [`SOLFL_LED_COUNT-1:0] orange_reg;
  logic         fault_reg;
  logic         fault_next;
  logic         misoMeta_reg;
  logic         miso_reg;
  logic         misoOe_reg;

  logic         logicClear;
  logic         latchEvent;
  solfl_chan_t  commanded;
  solfl_chan_t  heatOff;
  solfl_chan_t  tripped;
  solfl_chan_t  tripStart;

  // ***************************************************************
  // Link side
  // ***************************************************************

  assign lnk.spiMosi      = spiMosi;
  assign lnk.selectLatchN = selectLatchN;
  assign lnk.linkClear    = linkClear_reg;

  // Serial clock comes only from the host; nothing here makes it
  solfl_link_shift i_solfl_link_shift
  (
    .spiClk (spiClk),
    .lnk    (lnk.link)
  );

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************

  always_ff @(posedge clk_sys)
  begin
    clrMeta_reg <= outputClear;
    clrSync_reg <= clrMeta_reg;
  end

  // Power stage flags are levels; no reset, they settle in two cycles
  always_ff @(posedge clk_sys)
  begin
    ocMeta_reg <= overCurrent;
    ocSync_reg <= ocMeta_reg;
  end

  always_ff @(posedge clk_sys)
  begin
    otMeta_reg <= overTemp;
    otSync_reg <= otMeta_reg;
  end

  // Select idles high so a reset must not fake a rising edge
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      selMeta_reg <= 1'h1;
      selSync_reg <= 1'h1;
      selLast_reg <= 1'h1;
    end
    else
    begin
      selMeta_reg <= selectLatchN;
      selSync_reg <= selMeta_reg;
      selLast_reg <= selSync_reg;
    end
  end

  // The shift word is quiet from the last serial edge until well after
  // select rises, so a plain two-stage capture sees one settled value.
  always_ff @(posedge clk_sys)
  begin
    wordMeta_reg <= lnk.shiftWord;
    wordSync_reg <= wordMeta_reg;
  end

  // ***************************************************************
  // Clear and latch decode
  // ***************************************************************

  assign logicClear = sys_rst | clrSync_reg;
  assign latchEvent = selSync_reg & ~selLast_reg;

  always_ff @(posedge clk_sys)
  begin
    linkClear_reg <= logicClear;
  end

  // ***************************************************************
  // Frame latch
  // ***************************************************************

  // Frame moves only on the select edge or a clear; shifting alone changes nothing
  assign frame_next = latchEvent ? wordSync_reg : frame_reg;

  always_ff @(posedge clk_sys)
  begin
    if (logicClear)
      frame_reg <= `SOLFL_FRAME_ZERO;
    else
      frame_reg <= frame_next;
  end

  assign commanded = frame_reg[`SOLFL_LOAD_MSB:`SOLFL_LOAD_LSB];

  // ***************************************************************
  // Overcurrent retry, one timer per channel
  // ***************************************************************

  // Over temperature blanks the whole driver only while it lasts
  assign heatOff = groupSpread(otSync_reg);

  genvar ch;
  generate
    for (ch = 0; ch < `SOLFL_LOAD_COUNT; ch++)
    begin : g_chan
      solfl_chan_e  state_reg;
      solfl_chan_e  state_next;
      solfl_retry_t count_reg;
      solfl_retry_t count_next;
      logic         countDone;

      // A trip is only possible on a channel that is actually driven
      assign tripStart[ch] = (state_reg == CH_RUN) & commanded[ch]
                           & ~heatOff[ch] & ocSync_reg[ch];
      // Off for the trip cycle plus RETRY_CYCLES cycles in the trip state
      assign countDone     = (count_reg == `SOLFL_RETRY_ONE);
      assign tripped[ch]   = (state_reg == CH_TRIP);

      always_comb
      begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
          CH_RUN:
          begin
            if (tripStart[ch])
            begin
              state_next = CH_TRIP;
              count_next = RETRY_CYCLES[`SOLFL_RETRY_W-1:0];
            end
          end
          CH_TRIP:
          begin
            // Retry re-arms the channel; a lasting short trips it again
            if (countDone)
            begin
              state_next = CH_RUN;
              count_next = `SOLFL_RETRY_ZERO;
            end
            else
              count_next = count_reg - `SOLFL_RETRY_ONE;
          end
          default:
          begin
            state_next = CH_RUN;
            count_next = `SOLFL_RETRY_ZERO;
          end
        endcase
      end

      always_ff @(posedge clk_sys)
      begin
        if (logicClear)
        begin
          state_reg <= CH_RUN;
          count_reg <= `SOLFL_RETRY_ZERO;
        end
        else
        begin
          state_reg <= state_next;
          count_reg <= count_next;
        end
      end
    end
  endgenerate

  // ***************************************************************
  // Output drivers and fault line
  // ***************************************************************

  // The trip cycle itself already gates the driver, matching the fault
  assign load_next  = commanded & ~heatOff & ~tripped
                    & ~tripStart;
  assign fault_next = (|tripped) | (|tripStart)
                    | (|otSync_reg);

  always_ff @(posedge clk_sys)
  begin
    if (logicClear)
    begin
      load_reg  <= `SOLFL_BYTE_ZERO;
      fault_reg <= 1'h0;
    end
    else
    begin
      load_reg  <= load_next;
      fault_reg <= fault_next;
    end
  end

  // LEDs change in the same cycle as the loads; they only show what was latched
  always_ff @(posedge clk_sys)
  begin
    if (logicClear)
    begin
      red_reg    <= `SOLFL_BYTE_ZERO;
      orange_reg <= `SOLFL_BYTE_ZERO;
    end
    else
    begin
      red_reg    <= ledPick(frame_reg, 1'h1);
      orange_reg <= ledPick(frame_reg, 1'h0);
    end
  end

  // ***************************************************************
  // Serial data out
  // ***************************************************************

  // ***************************************************************
  // Chain out synchroniser
  // ***************************************************************

  // The chain bit moves on the serial clock, so it gets two core flops
  // before the pin; the extra cycle is far inside one bit time.
  always_ff @(posedge clk_sys)
  begin
    misoMeta_reg <= lnk.misoBit;
  end

  always_ff @(posedge clk_sys)
  begin
    if (logicClear)
      miso_reg <= 1'h0;
    else
      miso_reg <= misoMeta_reg;
  end

  // Released while deselected so other cards can share the return line.
  // Drive follows the synchronised select, a few core cycles late,
  // which is far inside one bit time even at the top serial rate.
  always_ff @(posedge clk_sys)
  begin
    if (logicClear)
      misoOe_reg <= 1'h0;
    else
      misoOe_reg <= ~selSync_reg;
  end

  // ***************************************************************
  // Port drive
  // ***************************************************************

  assign loadSwitchOutputs = load_reg;
  assign ledRed            = red_reg;
  assign ledOrange         = orange_reg;
  assign globalFaultN      = ~fault_reg;
  assign misoOut           = miso_reg;
  assign misoOeN           = ~misoOe_reg;

endmodule : solfl_top

// ===== sim/solfl_top_monitor.sv
`timescale 1ns/1ps
`include "solfl_defs.svh"

// ****************
// Port checker
// ****************
module solfl_top_monitor
#(
  parameter int RETRY_CYCLES = 20
)
(
  input wire logic                            clk_sys,
  input wire logic                            sys_rst,
  input wire logic                            selectLatchN,
  input wire logic                            misoOeN,
  input wire logic                            outputClear,
  input wire logic [`SOLFL_LOAD_COUNT-1:0]    overCurrent,
  input wire logic [`SOLFL_GROUP_COUNT-1:0]   overTemp,
  input wire logic [`SOLFL_LOAD_COUNT-1:0]    loadSwitchOutputs,
  input wire logic                            globalFaultN
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  int         lowRun;
  logic       spanClean;
  logic [3:0] causeHist;

  // Clear and heat end a fault early, so such spans say nothing on retry
  always_ff @(posedge clk_sys)
  begin
    lowRun    <= globalFaultN ? 0 : lowRun + 1;
    spanClean <= globalFaultN | (spanClean & ~outputClear & ~|overTemp);
    causeHist <= {causeHist[2:0], (|overCurrent) | (|overTemp)};
  end

  reset_state_a: assert property ($fell(sys_rst) |->
    loadSwitchOutputs == 8'h00 && globalFaultN && misoOeN)
    else $error("outputs not idle after reset");
  clear_off_a: assert property ((outputClear && overTemp == 2'h0) [*4]
    |-> loadSwitchOutputs == 8'h00 && globalFaultN)
    else $error("clear left outputs or fault active");
  fault_cause_a: assert property ($fell(globalFaultN) |-> causeHist != 4'h0)
    else $error("fault without a cause");
  trip_off_a: assert property ($rose(overCurrent[0]) && loadSwitchOutputs[0]
    && !outputClear ##1 overCurrent[0] [*2] |-> ##[0:1]
    (!loadSwitchOutputs[0] && !globalFaultN))
    else $error("overcurrent did not trip channel");
  retry_len_a: assert property ($rose(globalFaultN) && spanClean
    |-> lowRun >= RETRY_CYCLES - 1)
    else $error("retry came too early");
  heat_low_a: assert property (overTemp[0] [*5]
    |-> loadSwitchOutputs[3:0] == 4'h0 && !globalFaultN)
    else $error("heat left low group on");
  heat_high_a: assert property (overTemp[1] [*5]
    |-> loadSwitchOutputs[7:4] == 4'h0 && !globalFaultN)
    else $error("heat left high group on");
  latch_hold_a: assert property ((!selectLatchN && globalFaultN
    && !outputClear && overCurrent == 8'h00 && overTemp == 2'h0) [*6]
    |=> $stable(loadSwitchOutputs))
    else $error("outputs moved while shifting");
  miso_idle_a: assert property (selectLatchN [*4] |-> misoOeN)
    else $error("miso driven while deselected");

  cover property ($fell(globalFaultN));
  cover property ($rose(globalFaultN) && spanClean);
  cover property (overTemp[0] [*5]);
endmodule : solfl_top_monitor

bind solfl_top solfl_top_monitor #(.RETRY_CYCLES(RETRY_CYCLES)) i_solfl_top_monitor
(
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .selectLatchN(selectLatchN),
  .misoOeN(misoOeN),
  .outputClear(outputClear),
  .overCurrent(overCurrent),
  .overTemp(overTemp),
  .loadSwitchOutputs(loadSwitchOutputs),
  .globalFaultN(globalFaultN)
);

// ===== sim/solfl_host_model.sv
`timescale 1ns/1ps

// ****************
// Host master
// ****************
module solfl_host_model
(
  input  wire logic misoOut,
  input  wire logic misoOeN,
  output logic      spiClk,
  output logic      spiMosi,
  output logic      selectLatchN,
  output logic      outputClear
);
  logic misoSeen;

  initial
  begin
    spiClk       = 1'b0;
    spiMosi      = 1'b0;
    selectLatchN = 1'b1;
    outputClear  = 1'b0;
  end

  task automatic pulse_clear();
    outputClear = 1'b1;
    #200;
    outputClear = 1'b0;
    #200;
  endtask : pulse_clear

  // 80 ns clock only inside frames, MSB first
  task automatic send_bits(input logic [31:0] bits, input int n,
                           input int gapAt);
    #7 selectLatchN = 1'b0;
    #100;
    for (int i = n - 1; i >= 0; i--)
    begin
      spiMosi = bits[i];
      if (i == gapAt)
        #3000;
      #40 spiClk = 1'b1;
      #40 spiClk = 1'b0;
    end
    // Released line must not show its last value
    spiMosi = ~spiMosi;
    #200 misoSeen = misoOeN ? 1'bx : misoOut;
    selectLatchN = 1'b1;
    #200;
  endtask : send_bits
endmodule : solfl_host_model

// ===== sim/solfl_top_test.sv
`timescale 1ns/1ps

// ****************
// Bench
// ****************
module solfl_top_test;
  import solfl_pkg::*;

  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       spiClk;
  logic       spiMosi;
  logic       selectLatchN;
  logic       outputClear;
  logic       misoOut;
  logic       misoOeN;
  logic [7:0] overCurrent;
  logic [1:0] overTemp;
  logic [7:0] loadSwitchOutputs;
  logic [7:0] ledRed;
  logic [7:0] ledOrange;
  logic       globalFaultN;
  int         failures = 0;
  int         checked = 0;

  always #10 clk_sys = ~clk_sys;

  solfl_top #(.RETRY_CYCLES(20)) i_solfl_top
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .spiClk(spiClk),
    .spiMosi(spiMosi), .selectLatchN(selectLatchN), .misoOut(misoOut),
    .misoOeN(misoOeN), .outputClear(outputClear),
    .overCurrent(overCurrent), .overTemp(overTemp),
    .loadSwitchOutputs(loadSwitchOutputs), .ledRed(ledRed),
    .ledOrange(ledOrange), .globalFaultN(globalFaultN)
  );

  solfl_host_model i_solfl_host_model
  (
    .misoOut(misoOut), .misoOeN(misoOeN), .spiClk(spiClk),
    .spiMosi(spiMosi), .selectLatchN(selectLatchN),
    .outputClear(outputClear)
  );

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick

  function automatic logic [7:0] pick(input logic [23:0] f, input int odd);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = f[2 * i + odd];
    return r;
  endfunction : pick

  task automatic report_and_stop();
    $display("checked %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // Last 24 bits form the frame; a stalled clock must not lose state
  task automatic test_frame(input logic [31:0] bits, input int n);
    i_solfl_host_model.send_bits(bits, n, 12);
    tick(6);
    check("loads", loadSwitchOutputs, bits[23:16]);
    check("red", ledRed, pick(bits[23:0], 1));
    check("orange", ledOrange, pick(bits[23:0], 0));
    check("chain out", i_solfl_host_model.misoSeen, bits[23]);
    $display("test_frame done");
  endtask : test_frame

  task automatic test_trip();
    overCurrent[0] = 1'b1;
    tick(4);
    check("trip load", loadSwitchOutputs, 8'h0E);
    check("trip fault", globalFaultN, 1'b0);
    overCurrent[7] = 1'b1;
    tick(10);
    overCurrent = 8'h00;
    tick(4);
    check("still off", loadSwitchOutputs, 8'h0E);
    tick(8);
    check("retry load", loadSwitchOutputs, 8'h0F);
    check("retry fault", globalFaultN, 1'b1);
    $display("test_trip done");
  endtask : test_trip

  task automatic test_heat();
    for (int g = 0; g < 2; g++)
    begin
      overTemp = 2'h1 << g;
      tick(5);
      check("heat load", loadSwitchOutputs,
            8'h0F & ~(8'h0F << (4 * g)));
      check("heat fault", globalFaultN, 1'b0);
      overTemp = 2'h0;
      tick(5);
      check("cool load", loadSwitchOutputs, 8'h0F);
      check("cool fault", globalFaultN, 1'b1);
    end
    $display("test_heat done");
  endtask : test_heat

  task automatic test_clear();
    overCurrent[1] = 1'b1;
    tick(5);
    // Clear must lift the fault long before the retry would
    fork
      i_solfl_host_model.pulse_clear();
      begin
        tick(8);
        check("clear early", globalFaultN, 1'b1);
        check("clear off", loadSwitchOutputs, 8'h00);
      end
    join
    tick(1);
    overCurrent = 8'h00;
    check("clear fault", globalFaultN, 1'b1);
    tick(25);
    check("clear load", loadSwitchOutputs, 8'h00);
    check("clear led", {ledRed, ledOrange}, 16'h0000);
    $display("test_clear done");
  endtask : test_clear

  initial
  begin
    overCurrent = 8'h00;
    overTemp    = 2'h0;
    tick(6);
    sys_rst = 1'b0;
    tick(1);
    check("reset fault", globalFaultN, 1'b1);
    i_solfl_host_model.pulse_clear();
    test_frame(32'h00A5C396, 24);
    test_frame(32'h5A0FF03C, 32);
    tick(1);
    test_trip();
    test_heat();
    test_clear();
    report_and_stop();
  end

  initial
  begin
    #500000;
    failures++;
    report_and_stop();
  end
endmodule : solfl_top_test
